// ==== include/spm_pkg.sv ====
// Constants shared by the serial port pin multiplexer and its register file
package spm_pkg;

    // Core data memory bus widths
    localparam int unsigned SPM_ADDR_W = 14;
    localparam int unsigned SPM_DATA_W = 16;

    // Register addresses in data memory space
    localparam logic [13:0] SPM_ADDR_MODE_CTRL = 14'h2015;
    localparam logic [13:0] SPM_ADDR_SYS_CTRL  = 14'h3FFF;

    // Implemented widths of the two registers
    localparam int unsigned SPM_MODE_CTRL_W = 9;
    localparam int unsigned SPM_SYS_CTRL_W  = 16;

    // Field positions
    localparam int unsigned SPM_BIT_RX_PIN_SELECT = 4;
    localparam int unsigned SPM_BIT_UART_MODE     = 5;
    localparam int unsigned SPM_BIT_ALT_CONFIG    = 10;

    // Values after reset
    localparam logic [8:0]  SPM_MODE_CTRL_RESET = 9'h000;
    localparam logic [15:0] SPM_SYS_CTRL_RESET  = 16'h0000;

    // Level shown on an idle active-low interrupt line and on idle serial inputs
    localparam logic SPM_IRQ_IDLE  = 1'b1;
    localparam logic SPM_LINE_IDLE = 1'b0;

    // Read data for an unmapped address
    localparam logic [15:0] SPM_UNMAPPED_READ = 16'h0000;

endpackage

// ==== src/spm_pin_mux.sv ====
// Serial port pin multiplexer: normal, UART and alternate flag/interrupt pin use
//
// Summary of operation
// [R1] Bit 10 of core system control at 0x3FFF selects the alternate pin configuration.
// [R2] Alternate: the selected receive pin becomes the flag input.
// [R3] Alternate: transmit-data pin drives the flag output instead of serial data.
// [R4] Alternate: receive frame-sync pin becomes external interrupt zero input.
// [R5] Alternate: transmit frame-sync pin becomes external interrupt one input.
// [R6] Serial clock pin keeps working as serial clock in alternate configuration.
// [R7] Mode control bit 4 picks second receive pin when set, first when clear.
// [R8] Mode control bit 5 joins receive data and frame sync, drives core flag out.
// [R9] Alternate bit clear returns data and frame-sync pins to serial port use.
module spm_pin_mux
    import spm_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    // Core data memory bus
    input  wire logic [SPM_ADDR_W-1:0] dm_addr_in,
    input  wire logic                  dm_wr_in,
    input  wire logic                  dm_rd_in,
    input  wire logic [SPM_DATA_W-1:0] dm_wdata_in,
    output logic      [SPM_DATA_W-1:0] dm_rdata_out,
    // Device pins
    input  wire logic                  receive_pin_first_in,
    input  wire logic                  receive_pin_second_in,
    output logic                       serial_transmit_data_out,
    output logic                       serial_transmit_data_oe_out,
    input  wire logic                  receive_frame_sync_in,
    output logic                       receive_frame_sync_out,
    output logic                       receive_frame_sync_oe_out,
    input  wire logic                  transmit_frame_sync_in,
    output logic                       transmit_frame_sync_out,
    output logic                       transmit_frame_sync_oe_out,
    input  wire logic                  serial_port_clock_in,
    output logic                       serial_port_clock_out,
    output logic                       serial_port_clock_oe_out,
    // Synchronous serial port side
    output logic                       ssp_receive_data_out,
    output logic                       ssp_receive_frame_sync_out,
    output logic                       ssp_transmit_frame_sync_out,
    output logic                       ssp_clock_out,
    input  wire logic                  ssp_transmit_data_in,
    input  wire logic                  ssp_transmit_data_en_in,
    input  wire logic                  ssp_receive_frame_sync_in,
    input  wire logic                  ssp_receive_frame_sync_en_in,
    input  wire logic                  ssp_transmit_frame_sync_in,
    input  wire logic                  ssp_transmit_frame_sync_en_in,
    input  wire logic                  ssp_clock_in,
    input  wire logic                  ssp_clock_en_in,
    // Core side
    output logic                       flag_input_out,
    input  wire logic                  flag_output_in,
    input  wire logic                  core_output_flag_in,
    output logic                       external_interrupt_zero_b_out,
    output logic                       external_interrupt_one_b_out,
    output logic                       alt_config_out,
    output logic                       uart_mode_out
);
    import spm_pkg::*;

    logic [SPM_MODE_CTRL_W-1:0] peripheral_mode_control;
    logic [SPM_SYS_CTRL_W-1:0]  core_system_control;

    spm_reg_file u_regs (
        .clk_in                      (clk_in),
        .rst_b_in                    (rst_b_in),
        .dm_addr_in                  (dm_addr_in),
        .dm_wr_in                    (dm_wr_in),
        .dm_rd_in                    (dm_rd_in),
        .dm_wdata_in                 (dm_wdata_in),
        .dm_rdata_out                (dm_rdata_out),
        .peripheral_mode_control_out (peripheral_mode_control),
        .core_system_control_out     (core_system_control)
    );

    // Configuration decode
    wire alt_config         = core_system_control[SPM_BIT_ALT_CONFIG];         // R1
    wire receive_pin_select = peripheral_mode_control[SPM_BIT_RX_PIN_SELECT];
    wire uart_mode          = peripheral_mode_control[SPM_BIT_UART_MODE];

    // Receive pin selection feeds both the serial port and the flag input
    wire serial_receive_data = receive_pin_select ? receive_pin_second_in
                                                  : receive_pin_first_in;      // R7

    // Flag input follows the selected pin only while alternate use is active
    wire next_flag_input = alt_config ? serial_receive_data : SPM_LINE_IDLE;   // R2

    // Serial port receive data is held idle while the pin serves as a flag
    wire next_ssp_receive_data = alt_config ? SPM_LINE_IDLE
                                            : serial_receive_data;             // R9

    // In UART emulation the internal frame sync is taken from the receive data line
    wire next_ssp_receive_frame_sync = alt_config ? SPM_LINE_IDLE :
                                       uart_mode  ? serial_receive_data :      // R8
                                                    receive_frame_sync_in;     // R9

    wire next_ssp_transmit_frame_sync = alt_config ? SPM_LINE_IDLE
                                                   : transmit_frame_sync_in;   // R9

    // Transmit data pin: flag output or serial data
    wire next_tx_data    = alt_config ? flag_output_in : ssp_transmit_data_in;    // R3
    wire next_tx_data_oe = alt_config ? 1'b1           : ssp_transmit_data_en_in; // R3

    // Receive frame-sync pin. Alternate use wins over UART emulation because the
    // pin cannot be an interrupt input and a driven flag at the same time.
    wire next_rfs_pin    = uart_mode ? core_output_flag_in
                                     : ssp_receive_frame_sync_in;              // R8
    wire next_rfs_pin_oe = alt_config ? 1'b0 :                                 // R4
                           uart_mode  ? 1'b1 :                                 // R8
                                        ssp_receive_frame_sync_en_in;          // R9

    // Transmit frame-sync pin
    wire next_tfs_pin    = ssp_transmit_frame_sync_in;
    wire next_tfs_pin_oe = alt_config ? 1'b0
                                      : ssp_transmit_frame_sync_en_in;         // R5

    // Interrupt lines are active low and idle high outside alternate use
    wire next_irq_zero_b = alt_config ? receive_frame_sync_in  : SPM_IRQ_IDLE; // R4
    wire next_irq_one_b  = alt_config ? transmit_frame_sync_in : SPM_IRQ_IDLE; // R5

    // Serial clock is passed through in every configuration
    wire next_sclk_pin    = ssp_clock_in;                                      // R6
    wire next_sclk_pin_oe = ssp_clock_en_in;                                   // R6
    wire next_ssp_clock   = serial_port_clock_in;                              // R6

    logic flag_input;
    logic ssp_receive_data;
    logic ssp_receive_frame_sync;
    logic ssp_transmit_frame_sync;
    logic ssp_clock;
    logic tx_data;
    logic tx_data_oe;
    logic rfs_pin;
    logic rfs_pin_oe;
    logic tfs_pin;
    logic tfs_pin_oe;
    logic sclk_pin;
    logic sclk_pin_oe;
    logic irq_zero_b;
    logic irq_one_b;

    // Registered pin path: one cycle of latency buys glitch-free pin switching
    // when a configuration bit is rewritten mid-transfer.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_input              <= SPM_LINE_IDLE;
            ssp_receive_data        <= SPM_LINE_IDLE;
            ssp_receive_frame_sync  <= SPM_LINE_IDLE;
            ssp_transmit_frame_sync <= SPM_LINE_IDLE;
            ssp_clock               <= SPM_LINE_IDLE;
            irq_zero_b              <= SPM_IRQ_IDLE;
            irq_one_b               <= SPM_IRQ_IDLE;
        end else begin
            flag_input              <= next_flag_input;
            ssp_receive_data        <= next_ssp_receive_data;
            ssp_receive_frame_sync  <= next_ssp_receive_frame_sync;
            ssp_transmit_frame_sync <= next_ssp_transmit_frame_sync;
            ssp_clock               <= next_ssp_clock;
            irq_zero_b              <= next_irq_zero_b;
            irq_one_b               <= next_irq_one_b;
        end
    end

    // Pins stay undriven through reset
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_data     <= SPM_LINE_IDLE;
            tx_data_oe  <= 1'b0;
            rfs_pin     <= SPM_LINE_IDLE;
            rfs_pin_oe  <= 1'b0;
            tfs_pin     <= SPM_LINE_IDLE;
            tfs_pin_oe  <= 1'b0;
            sclk_pin    <= SPM_LINE_IDLE;
            sclk_pin_oe <= 1'b0;
        end else begin
            tx_data     <= next_tx_data;
            tx_data_oe  <= next_tx_data_oe;
            rfs_pin     <= next_rfs_pin;
            rfs_pin_oe  <= next_rfs_pin_oe;
            tfs_pin     <= next_tfs_pin;
            tfs_pin_oe  <= next_tfs_pin_oe;
            sclk_pin    <= next_sclk_pin;
            sclk_pin_oe <= next_sclk_pin_oe;
        end
    end

    assign flag_input_out                = flag_input;
    assign ssp_receive_data_out          = ssp_receive_data;
    assign ssp_receive_frame_sync_out    = ssp_receive_frame_sync;
    assign ssp_transmit_frame_sync_out   = ssp_transmit_frame_sync;
    assign ssp_clock_out                 = ssp_clock;
    assign external_interrupt_zero_b_out = irq_zero_b;
    assign external_interrupt_one_b_out  = irq_one_b;
    assign serial_transmit_data_out      = tx_data;
    assign serial_transmit_data_oe_out   = tx_data_oe;
    assign receive_frame_sync_out        = rfs_pin;
    assign receive_frame_sync_oe_out     = rfs_pin_oe;
    assign transmit_frame_sync_out       = tfs_pin;
    assign transmit_frame_sync_oe_out    = tfs_pin_oe;
    assign serial_port_clock_out         = sclk_pin;
    assign serial_port_clock_oe_out      = sclk_pin_oe;
    assign alt_config_out                = alt_config;
    assign uart_mode_out                 = uart_mode;

endmodule

// ==== src/spm_reg_file.sv ====
// Mode control and system control registers on the core data memory bus
module spm_reg_file
    import spm_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   rst_b_in,
    input  wire logic [SPM_ADDR_W-1:0]  dm_addr_in,
    input  wire logic                   dm_wr_in,
    input  wire logic                   dm_rd_in,
    input  wire logic [SPM_DATA_W-1:0]  dm_wdata_in,
    output logic      [SPM_DATA_W-1:0]  dm_rdata_out,
    output logic      [SPM_MODE_CTRL_W-1:0] peripheral_mode_control_out,
    output logic      [SPM_SYS_CTRL_W-1:0]  core_system_control_out
);
    import spm_pkg::*;

    function automatic logic addr_hit(input logic [SPM_ADDR_W-1:0] a, input logic [SPM_ADDR_W-1:0] target);
        addr_hit = (a == target);
    endfunction

    logic [SPM_MODE_CTRL_W-1:0] peripheral_mode_control;
    logic [SPM_SYS_CTRL_W-1:0]  core_system_control;
    logic [SPM_DATA_W-1:0]      dm_rdata;

    wire                  hit_mode = addr_hit(dm_addr_in, SPM_ADDR_MODE_CTRL);
    wire                  hit_sys  = addr_hit(dm_addr_in, SPM_ADDR_SYS_CTRL);
    wire                  wr_mode  = dm_wr_in && hit_mode;
    wire                  wr_sys   = dm_wr_in && hit_sys;
    wire [SPM_DATA_W-1:0] next_rdata;

    // Unused upper bits of the narrow register read as zero
    assign next_rdata = hit_mode ? {{(SPM_DATA_W-SPM_MODE_CTRL_W){1'b0}}, peripheral_mode_control} :
                        hit_sys  ? core_system_control :
                                   SPM_UNMAPPED_READ;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            peripheral_mode_control <= SPM_MODE_CTRL_RESET;
            core_system_control     <= SPM_SYS_CTRL_RESET;
            dm_rdata                <= SPM_UNMAPPED_READ;
        end else begin
            if (wr_mode) begin
                peripheral_mode_control <= dm_wdata_in[SPM_MODE_CTRL_W-1:0];
            end
            if (wr_sys) begin
                core_system_control <= dm_wdata_in;
            end
            if (dm_rd_in) begin
                dm_rdata <= next_rdata;
            end
        end
    end

    assign dm_rdata_out                = dm_rdata;
    assign peripheral_mode_control_out = peripheral_mode_control;
    assign core_system_control_out     = core_system_control;

endmodule

// ==== test/spm_pin_mux_assertions.sv ====
// Checker on the ports of the serial port pin multiplexer
module spm_pin_mux_assertions
    import spm_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic [SPM_ADDR_W-1:0] dm_addr_in,
    input  wire logic                  dm_wr_in,
    input  wire logic [SPM_DATA_W-1:0] dm_wdata_in,
    input  wire logic                  alt_config_out,
    input  wire logic                  uart_mode_out,
    input  wire logic                  receive_pin_first_in,
    input  wire logic                  receive_pin_second_in,
    input  wire logic                  flag_input_out,
    input  wire logic                  flag_output_in,
    input  wire logic                  serial_transmit_data_out,
    input  wire logic                  serial_transmit_data_oe_out,
    input  wire logic                  receive_frame_sync_in,
    input  wire logic                  receive_frame_sync_out,
    input  wire logic                  receive_frame_sync_oe_out,
    input  wire logic                  transmit_frame_sync_in,
    input  wire logic                  external_interrupt_zero_b_out,
    input  wire logic                  external_interrupt_one_b_out,
    input  wire logic                  serial_port_clock_in,
    input  wire logic                  ssp_clock_out,
    input  wire logic                  ssp_transmit_data_en_in,
    input  wire logic                  core_output_flag_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import spm_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // Equal receive pins make the check independent of the pin select
    a_alt_flag_in: assert property (alt_config_out && receive_pin_first_in == receive_pin_second_in
        |=> flag_input_out == $past(receive_pin_first_in)) else $error("flag input does not follow receive pin");
    a_alt_flag_out: assert property (alt_config_out
        |=> serial_transmit_data_oe_out && serial_transmit_data_out == $past(flag_output_in))
        else $error("transmit pin does not carry flag output");
    a_alt_irq_zero: assert property (alt_config_out
        |=> !receive_frame_sync_oe_out && external_interrupt_zero_b_out == $past(receive_frame_sync_in))
        else $error("interrupt zero does not follow frame sync pin");
    a_alt_irq_one: assert property (alt_config_out
        |=> external_interrupt_one_b_out == $past(transmit_frame_sync_in)) else $error("interrupt one wrong");
    a_clock_kept: assert property (alt_config_out
        |=> ssp_clock_out == $past(serial_port_clock_in)) else $error("serial clock lost in alternate use");
    a_normal_idle: assert property (!alt_config_out |=> !flag_input_out && external_interrupt_zero_b_out
        && external_interrupt_one_b_out && serial_transmit_data_oe_out == $past(ssp_transmit_data_en_in))
        else $error("normal pin use not restored");
    a_uart_flag_route: assert property (uart_mode_out && !alt_config_out
        |=> receive_frame_sync_oe_out && receive_frame_sync_out == $past(core_output_flag_in))
        else $error("core flag not on frame sync pin");
    a_alt_bit_write: assert property (dm_wr_in && dm_addr_in == SPM_ADDR_SYS_CTRL
        |=> alt_config_out == $past(dm_wdata_in[SPM_BIT_ALT_CONFIG])) else $error("alternate bit not written");
endmodule

// ==== test/spm_pin_partner.sv ====
// Far-side model: drives receive, frame-sync and clock pins
module spm_pin_partner (
    input  wire logic [4:0] ext_in,
    input  wire logic [2:0] drv_in,
    input  wire logic [2:0] oe_in,
    output logic      [4:0] pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    assign pin_out[4:3] = ext_in[4:3];
    // Shared pins yield to the device while it drives them, so no contention is modelled
    assign pin_out[2:0] = (oe_in & drv_in) | (~oe_in & ext_in[2:0]);
endmodule

// ==== test/test_spm_pin_mux.sv ====
// Bench for the serial port pin multiplexer
module test_spm_pin_mux;
    timeunit 1ns;
    timeprecision 1ns;
    import spm_pkg::*;
    logic clk_in = 1'b0, rst_b_in = 1'b0, dm_wr_in = 1'b0, dm_rd_in = 1'b0;
    logic [13:0] dm_addr_in = 14'h0000;
    logic [15:0] dm_wdata_in = 16'h0000, dm_rdata_out;
    logic receive_pin_first_in, receive_pin_second_in, receive_frame_sync_in, transmit_frame_sync_in;
    logic serial_port_clock_in, serial_transmit_data_out, serial_transmit_data_oe_out, receive_frame_sync_out;
    logic receive_frame_sync_oe_out, transmit_frame_sync_out, transmit_frame_sync_oe_out, serial_port_clock_out;
    logic serial_port_clock_oe_out, ssp_receive_data_out, ssp_receive_frame_sync_out, ssp_transmit_frame_sync_out;
    logic ssp_clock_out, flag_input_out, external_interrupt_zero_b_out, external_interrupt_one_b_out;
    logic alt_config_out, uart_mode_out, ssp_transmit_data_in, ssp_transmit_data_en_in, ssp_receive_frame_sync_in;
    logic ssp_receive_frame_sync_en_in, ssp_transmit_frame_sync_in, ssp_transmit_frame_sync_en_in, ssp_clock_in;
    logic ssp_clock_en_in = 1'b0, flag_output_in, core_output_flag_in;
    int bad_count = 0;
    int n_compared = 0;
    // alt uart sel | pins rfs tfs ck | fo cf | td en | fi i0 i1 srx srfs stfs txo txoe sck
    logic [20:0] cur = 21'h00000;
    logic [20:0] rows [7] = '{21'b000_10101_10_00_011110001, 21'b001_10000_01_11_011011110,
        21'b010_01011_01_00_011001001, 21'b011_01000_00_11_011111110, 21'b100_10011_10_01_101000111,
        21'b111_01010_01_11_101000010, 21'b100_00110_00_00_011000010};
    assign {flag_output_in, core_output_flag_in, ssp_transmit_data_in, ssp_transmit_data_en_in} = cur[12:9];
    assign {ssp_receive_frame_sync_in, ssp_transmit_frame_sync_in, ssp_clock_in} = {3{cur[10]}};
    assign {ssp_receive_frame_sync_en_in, ssp_transmit_frame_sync_en_in} = {2{cur[9]}};
    // Clock pin is left to the far side in the table so the pass-through is seen from outside
    spm_pin_mux i_spm_pin_mux (
        .clk_in, .rst_b_in, .dm_addr_in, .dm_wr_in, .dm_rd_in, .dm_wdata_in, .dm_rdata_out,
        .receive_pin_first_in, .receive_pin_second_in, .serial_transmit_data_out, .serial_transmit_data_oe_out,
        .receive_frame_sync_in, .receive_frame_sync_out, .receive_frame_sync_oe_out,
        .transmit_frame_sync_in, .transmit_frame_sync_out, .transmit_frame_sync_oe_out,
        .serial_port_clock_in, .serial_port_clock_out, .serial_port_clock_oe_out,
        .ssp_receive_data_out, .ssp_receive_frame_sync_out, .ssp_transmit_frame_sync_out, .ssp_clock_out,
        .ssp_transmit_data_in, .ssp_transmit_data_en_in, .ssp_receive_frame_sync_in, .ssp_receive_frame_sync_en_in,
        .ssp_transmit_frame_sync_in, .ssp_transmit_frame_sync_en_in, .ssp_clock_in, .ssp_clock_en_in,
        .flag_input_out, .flag_output_in, .core_output_flag_in,
        .external_interrupt_zero_b_out, .external_interrupt_one_b_out, .alt_config_out, .uart_mode_out
    );
    spm_pin_partner i_spm_pin_partner (
        .ext_in  (cur[17:13]),
        .drv_in  ({receive_frame_sync_out, transmit_frame_sync_out, serial_port_clock_out}),
        .oe_in   ({receive_frame_sync_oe_out, transmit_frame_sync_oe_out, serial_port_clock_oe_out}),
        .pin_out ({receive_pin_first_in, receive_pin_second_in, receive_frame_sync_in, transmit_frame_sync_in,
                   serial_port_clock_in})
    );
    always #20 clk_in = ~clk_in;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [15:0] d);
        @(negedge clk_in);
        {dm_addr_in, dm_wdata_in, dm_wr_in} = {a, d, 1'b1};
        @(negedge clk_in);
        dm_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [13:0] a, input logic [15:0] e);
        @(negedge clk_in);
        {dm_addr_in, dm_rd_in} = {a, 1'b1};
        @(negedge clk_in);
        dm_rd_in = 1'b0;
        chk(dm_rdata_out, e);
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [15:0] idle_view();
        return {10'h000, flag_input_out, external_interrupt_zero_b_out, external_interrupt_one_b_out,
                alt_config_out, uart_mode_out, serial_transmit_data_oe_out};
    endfunction
    initial begin
        repeat (4) @(negedge clk_in);
        rst_b_in = 1'b1;
        chk(idle_view(), 16'h0018);
        rd(SPM_ADDR_SYS_CTRL, 16'h0000);
        rd(SPM_ADDR_MODE_CTRL, 16'h0000);
        wr(14'h2014, 16'hFFFF);
        rd(14'h2014, 16'h0000);
        wr(SPM_ADDR_MODE_CTRL, 16'hFFFF);
        rd(SPM_ADDR_MODE_CTRL, 16'h01FF);
        for (int i = 0; i < 7; i++) begin
            cur = rows[i];
            wr(SPM_ADDR_SYS_CTRL, {5'h00, cur[20], 10'h000});
            wr(SPM_ADDR_MODE_CTRL, {10'h000, cur[19:18], 4'h0});
            rd(SPM_ADDR_SYS_CTRL, {5'h00, cur[20], 10'h000});
            repeat (2) @(negedge clk_in);
            chk({7'h00, flag_input_out, external_interrupt_zero_b_out, external_interrupt_one_b_out,
                 ssp_receive_data_out, ssp_receive_frame_sync_out, ssp_transmit_frame_sync_out,
                 serial_transmit_data_out, serial_transmit_data_oe_out, ssp_clock_out},
                {7'h00, cur[8:0]});
        end
        // Reset in mid-run while the alternate pin use is active
        rst_b_in = 1'b0;
        @(negedge clk_in);
        rst_b_in = 1'b1;
        chk(idle_view(), 16'h0018);
        wr(SPM_ADDR_SYS_CTRL, 16'h0400);
        @(negedge clk_in);
        {dm_wdata_in, dm_wr_in, dm_rd_in} = {16'h0000, 1'b1, 1'b1};
        @(negedge clk_in);
        {dm_wr_in, dm_rd_in} = 2'b00;
        chk(dm_rdata_out, 16'h0400);
        // Pin outputs lag the register by one edge
        @(negedge clk_in);
        chk(idle_view(), 16'h0018);
        // Serial port drives all three shared pins in normal use
        cur = rows[1];
        ssp_clock_en_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk({9'h000, receive_frame_sync_oe_out, receive_frame_sync_out, transmit_frame_sync_oe_out,
             transmit_frame_sync_out, serial_port_clock_oe_out, serial_port_clock_out, ssp_clock_out},
            16'h007F);
        summarize();
    end
    initial begin
        #2000000;
        bad_count++;
        summarize();
    end
endmodule
bind spm_pin_mux spm_pin_mux_assertions i_spm_pin_mux_assertions (
    .clk_in, .rst_b_in, .dm_addr_in, .dm_wr_in, .dm_wdata_in, .alt_config_out, .uart_mode_out,
    .receive_pin_first_in, .receive_pin_second_in, .flag_input_out, .flag_output_in,
    .serial_transmit_data_out, .serial_transmit_data_oe_out, .receive_frame_sync_in,
    .receive_frame_sync_out, .receive_frame_sync_oe_out, .transmit_frame_sync_in,
    .external_interrupt_zero_b_out, .external_interrupt_one_b_out, .serial_port_clock_in,
    .ssp_clock_out, .ssp_transmit_data_en_in, .core_output_flag_in
);
